//--- srsp_pkg.sv
// Shared constants, types and helpers for the serial register port
package srsp_pkg;
  // ==========================================================
  // Frame layout
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int ADDR_BITS = 6;
  localparam int REG_COUNT = 64;
  localparam int CW_RW_POS = 7;
  localparam int CW_ADDR_LSB = 1;
  localparam int CW_BURST_POS = 0;
  localparam logic [5:0] BURST_LAST_ADDR = 6'h3f & 6'h1f;
  localparam logic [5:0] BURST_FIRST_ADDR = 6'h00;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [3:0] LAST_BIT_CNT = 4'hf;
  localparam logic [4:0] WORD_OUT_BITS = 5'h10;
  // ==========================================================
  // Timing
  localparam int SYS_CLK_NS = 100;
  localparam int SCLK_MIN_PERIOD_NS = 40;
  localparam int SCLK_MIN_HALF_CYC = (SCLK_MIN_PERIOD_NS / 2 + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int HOST_HALF_DIV = 8;
  // ==========================================================
  // Host register map
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_RDATA = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam int CTRL_IDLE = 0;
  localparam int CTRL_CAPT = 1;
  localparam int CTRL_REV = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_READ = 22;
  localparam int CMD_BURST = 23;
  localparam int CMD_LAST = 24;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_OPEN = 1;
  // ==========================================================
  // State encodings
  typedef enum logic [1:0] {
    SRSP_CMD = 2'h0, SRSP_WDATA = 2'h1, SRSP_RDATA = 2'h2
  } srsp_dphase_type;
  typedef enum logic [1:0] {
    SRSP_HIDLE = 2'h0, SRSP_HSETUP = 2'h1, SRSP_HRUN = 2'h3, SRSP_HHOLD = 2'h2
  } srsp_hphase_type;
  // ==========================================================
  // Bit reversal
  function automatic logic [5:0] rev6(input logic [5:0] v);
    for (int i = 0; i < 6; i++) rev6[i] = v[5 - i];
  endfunction : rev6
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15 - i];
  endfunction : rev16
endpackage : srsp_pkg

//--- srsp_link_if.sv
// Four-wire serial link between host and device
`timescale 1ns/1ps
`default_nettype none
interface srsp_link_if;
  logic sclk;
  logic cs_n;
  logic serial_in_line;
  logic serial_out_line;
  logic sdo_oe;
  modport device (input sclk, input cs_n, input serial_in_line, output serial_out_line, output sdo_oe);
  modport host (output sclk, output cs_n, output serial_in_line, input serial_out_line, input sdo_oe);
endinterface : srsp_link_if
`default_nettype wire

//--- srsp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module srsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      meta <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : srsp_sync
`default_nettype wire

//--- srsp_device.sv
// Device end of the serial register port with its register array
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module srsp_device (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Serial link
  srsp_link_if.device LINK,
  // Port configuration
  input wire logic CLOCK_IDLE_LEVEL,
  input wire logic CLOCK_CAPTURE_EDGE,
  input wire logic BIT_ORDER_REVERSE,
  input wire logic SERIAL_PORT_DISABLE,
  // Management-side register access
  input wire logic [srsp_pkg::ADDR_BITS-1:0] MGMT_ADDR,
  input wire logic MGMT_WRITE,
  input wire logic [srsp_pkg::DATA_BITS-1:0] MGMT_WDATA,
  output logic [srsp_pkg::DATA_BITS-1:0] MGMT_RDATA
);
  typedef struct packed {
    srsp_pkg::srsp_dphase_type phase;
    logic [7:0] cmd_sr;
    logic [15:0] rx_sr;
    logic [3:0] cap_cnt;
    logic [4:0] out_cnt;
    logic [5:0] addr;
    logic burst;
    logic [15:0] tx_word;
    logic sclk_prev;
    logic serial_out_line;
    logic sdo_oe;
    logic wr_en;
    logic [5:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] mgmt_rdata;
  } srsp_dstate_type;

  srsp_dstate_type st;
  srsp_dstate_type next_st;
  logic [15:0] mem [srsp_pkg::REG_COUNT];
  logic sclk_s;
  logic sdi_s;
  logic cs_n_s;

  // ==========================================================
  // Pin synchronisers
  srsp_sync #(.WIDTH(2), .RESET_VALUE(2'h0)) u_sync_data (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .d({LINK.sclk, LINK.serial_in_line}),
    .q({sclk_s, sdi_s})
  );
  srsp_sync #(.WIDTH(1), .RESET_VALUE(1'h1)) u_sync_sel (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .d(LINK.cs_n),
    .q(cs_n_s)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin : dev_next
    logic selected;
    logic lead;
    logic trail;
    logic capt;
    logic shft;
    logic [7:0] cw;
    logic [15:0] word;
    logic [5:0] na;
    logic [3:0] idx;
    selected = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    capt = 1'b0;
    shft = 1'b0;
    cw = 8'h00;
    word = 16'h0000;
    na = 6'h00;
    idx = 4'h0;
    next_st = st;
    next_st.sclk_prev = sclk_s;
    next_st.wr_en = 1'b0;
    next_st.mgmt_rdata = mem[MGMT_ADDR];
    selected = !cs_n_s && !SERIAL_PORT_DISABLE;
    lead = (sclk_s != CLOCK_IDLE_LEVEL) && (st.sclk_prev == CLOCK_IDLE_LEVEL);
    trail = (sclk_s == CLOCK_IDLE_LEVEL) && (st.sclk_prev != CLOCK_IDLE_LEVEL);
    capt = CLOCK_CAPTURE_EDGE ? trail : lead;
    shft = CLOCK_CAPTURE_EDGE ? lead : trail;
    if (SERIAL_PORT_DISABLE && MGMT_WRITE) begin
      next_st.wr_en = 1'b1;
      next_st.wr_addr = MGMT_ADDR;
      next_st.wr_data = MGMT_WDATA;
    end
    if (!selected) begin
      next_st.phase = srsp_pkg::SRSP_CMD;
      next_st.cap_cnt = 4'h0;
      next_st.out_cnt = 5'h00;
      next_st.serial_out_line = 1'b0;
      next_st.sdo_oe = 1'b0;
    end else begin
      unique case (st.phase)
        srsp_pkg::SRSP_CMD: begin
          if (capt) begin
            cw = {st.cmd_sr[6:0], sdi_s};
            next_st.cmd_sr = cw;
            next_st.cap_cnt = st.cap_cnt + 4'h1;
            if (st.cap_cnt == 4'(srsp_pkg::CMD_BITS - 1)) begin
              next_st.cap_cnt = 4'h0;
              na = cw[6:srsp_pkg::CW_ADDR_LSB];
              if (BIT_ORDER_REVERSE) begin
                na = srsp_pkg::rev6(na);
              end
              next_st.addr = na;
              next_st.burst = cw[srsp_pkg::CW_BURST_POS];
              if (cw[srsp_pkg::CW_RW_POS]) begin
                next_st.phase = srsp_pkg::SRSP_RDATA;
                next_st.tx_word = mem[na];
                next_st.out_cnt = 5'h00;
              end else begin
                next_st.phase = srsp_pkg::SRSP_WDATA;
              end
            end
          end
        end
        srsp_pkg::SRSP_WDATA: begin
          if (capt) begin
            word = BIT_ORDER_REVERSE ? {sdi_s, st.rx_sr[15:1]} : {st.rx_sr[14:0], sdi_s};
            next_st.rx_sr = word;
            next_st.cap_cnt = st.cap_cnt + 4'h1;
            if (st.cap_cnt == srsp_pkg::LAST_BIT_CNT) begin
              next_st.cap_cnt = 4'h0;
              next_st.wr_en = 1'b1;
              next_st.wr_addr = st.addr;
              next_st.wr_data = word;
              if (st.burst) begin
                next_st.addr = (st.addr == srsp_pkg::BURST_LAST_ADDR) ?
                  srsp_pkg::BURST_FIRST_ADDR : st.addr + 6'h01;
              end else begin
                next_st.phase = srsp_pkg::SRSP_CMD;
              end
            end
          end
        end
        srsp_pkg::SRSP_RDATA: begin
          if (shft && st.out_cnt < srsp_pkg::WORD_OUT_BITS) begin
            idx = BIT_ORDER_REVERSE ? st.out_cnt[3:0] : 4'hf - st.out_cnt[3:0];
            next_st.serial_out_line = st.tx_word[idx];
            next_st.sdo_oe = 1'b1;
            next_st.out_cnt = st.out_cnt + 5'h01;
          end
          if (capt) begin
            next_st.cap_cnt = st.cap_cnt + 4'h1;
            if (st.cap_cnt == srsp_pkg::LAST_BIT_CNT) begin
              next_st.cap_cnt = 4'h0;
              next_st.out_cnt = 5'h00;
              if (st.burst) begin
                na = (st.addr == srsp_pkg::BURST_LAST_ADDR) ?
                  srsp_pkg::BURST_FIRST_ADDR : st.addr + 6'h01;
                next_st.addr = na;
                next_st.tx_word = mem[na];
              end else begin
                next_st.phase = srsp_pkg::SRSP_CMD;
                next_st.sdo_oe = 1'b0;
              end
            end
          end
        end
        default: begin
          next_st.phase = srsp_pkg::SRSP_CMD;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Register array
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int i = 0; i < srsp_pkg::REG_COUNT; i++) begin
        mem[i] <= srsp_pkg::REG_RESET;
      end
    end else if (st.wr_en) begin
      mem[st.wr_addr] <= st.wr_data;
    end
  end

  // ==========================================================
  // Outputs
  assign LINK.serial_out_line = st.serial_out_line;
  assign LINK.sdo_oe = st.sdo_oe;
  assign MGMT_RDATA = st.mgmt_rdata;
endmodule : srsp_device
`default_nettype wire

//--- srsp_host.sv
// Host end: Avalon-MM command registers driving the serial link
`timescale 1ns/1ps
`default_nettype none
module srsp_host #(
  parameter int HALF_DIV = srsp_pkg::HOST_HALF_DIV
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Serial link
  srsp_link_if.host LINK
);
  typedef struct packed {
    srsp_pkg::srsp_hphase_type phase;
    logic [7:0] div;
    logic [5:0] edge_cnt;
    logic [4:0] nbits;
    logic [4:0] bitp;
    logic [23:0] seq;
    logic [15:0] rx;
    logic [15:0] rdata;
    logic [2:0] ctrl;
    logic last;
    logic burst_open;
    logic is_read;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic waitreq;
    logic [31:0] readdata;
  } srsp_hstate_type;

  srsp_hstate_type st;
  srsp_hstate_type next_st;
  logic miso_s;

  // ==========================================================
  // Return line synchroniser
  srsp_sync #(.WIDTH(1), .RESET_VALUE(1'h0)) u_sync_ret (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .d(LINK.serial_out_line),
    .q(miso_s)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin : host_next
    logic tick;
    logic lead;
    logic capt;
    logic rev;
    logic [15:0] word;
    logic [5:0] a;
    logic [7:0] cw;
    tick = 1'b0;
    lead = 1'b0;
    capt = 1'b0;
    rev = st.ctrl[srsp_pkg::CTRL_REV];
    word = 16'h0000;
    a = 6'h00;
    cw = 8'h00;
    next_st = st;
    next_st.waitreq = 1'b1;
    tick = (st.div == 8'(HALF_DIV - 1));
    // Register bus
    if (st.waitreq && AVS_READ) begin
      next_st.waitreq = 1'b0;
      unique case (AVS_ADDRESS)
        srsp_pkg::OFS_CTRL: next_st.readdata = {29'h0, st.ctrl};
        srsp_pkg::OFS_RDATA: next_st.readdata = {16'h0, st.rdata};
        srsp_pkg::OFS_STATUS: next_st.readdata = {30'h0, !st.cs_n, st.phase != srsp_pkg::SRSP_HIDLE};
        default: next_st.readdata = 32'h0;
      endcase
    end else if (st.waitreq && AVS_WRITE) begin
      if (AVS_ADDRESS == srsp_pkg::OFS_CTRL || AVS_ADDRESS == srsp_pkg::OFS_CMD) begin
        if (st.phase == srsp_pkg::SRSP_HIDLE) begin
          next_st.waitreq = 1'b0;
          if (AVS_ADDRESS == srsp_pkg::OFS_CTRL) begin
            next_st.ctrl = AVS_WRITEDATA[2:0];
            next_st.sclk = AVS_WRITEDATA[srsp_pkg::CTRL_IDLE];
          end else begin
            word = rev ? srsp_pkg::rev16(AVS_WRITEDATA[15:0]) : AVS_WRITEDATA[15:0];
            a = AVS_WRITEDATA[21:srsp_pkg::CMD_ADDR_LSB];
            cw = {AVS_WRITEDATA[srsp_pkg::CMD_READ], rev ? srsp_pkg::rev6(a) : a,
              AVS_WRITEDATA[srsp_pkg::CMD_BURST]};
            if (!st.cs_n && st.burst_open) begin
              next_st.seq = {word, 8'h00};
              next_st.nbits = 5'd16;
            end else begin
              next_st.seq = {cw, word};
              next_st.nbits = 5'd24;
              next_st.burst_open = AVS_WRITEDATA[srsp_pkg::CMD_BURST];
              next_st.is_read = AVS_WRITEDATA[srsp_pkg::CMD_READ];
            end
            next_st.last = AVS_WRITEDATA[srsp_pkg::CMD_LAST];
            next_st.cs_n = 1'b0;
            next_st.mosi = (!st.cs_n && st.burst_open) ? word[15] : cw[7];
            next_st.bitp = 5'd0;
            next_st.edge_cnt = 6'd0;
            next_st.div = 8'd0;
            next_st.rx = 16'h0000;
            next_st.phase = srsp_pkg::SRSP_HSETUP;
          end
        end
      end else begin
        next_st.waitreq = 1'b0;
      end
    end
    // Link sequencer
    unique case (st.phase)
      srsp_pkg::SRSP_HIDLE: begin
      end
      srsp_pkg::SRSP_HSETUP: begin
        next_st.div = tick ? 8'd0 : st.div + 8'd1;
        if (tick) next_st.phase = srsp_pkg::SRSP_HRUN;
      end
      srsp_pkg::SRSP_HRUN: begin
        next_st.div = tick ? 8'd0 : st.div + 8'd1;
        if (tick) begin
          lead = !st.edge_cnt[0];
          capt = st.ctrl[srsp_pkg::CTRL_CAPT] ? !lead : lead;
          next_st.sclk = !st.sclk;
          next_st.edge_cnt = st.edge_cnt + 6'd1;
          if (capt && st.edge_cnt[5:1] >= 5'(st.nbits - 5'd16)) begin
            next_st.rx = {st.rx[14:0], miso_s};
          end
          if (!capt && st.edge_cnt != 6'd0 && st.bitp + 5'd1 < st.nbits) begin
            next_st.bitp = st.bitp + 5'd1;
            next_st.mosi = st.seq[5'd22 - st.bitp];
          end
          if (st.edge_cnt == {st.nbits, 1'b0} - 6'd1) begin
            next_st.phase = srsp_pkg::SRSP_HHOLD;
            if (st.is_read) begin
              next_st.rdata = rev ? srsp_pkg::rev16(next_st.rx) : next_st.rx;
            end
          end
        end
      end
      srsp_pkg::SRSP_HHOLD: begin
        next_st.div = st.div + 8'd1;
        if (st.div == 8'(HALF_DIV - 1) && st.last) begin
          next_st.cs_n = 1'b1;
          next_st.burst_open = 1'b0;
        end
        if (st.div == 8'(2 * HALF_DIV - 1)) begin
          next_st.div = 8'd0;
          next_st.mosi = 1'b0;
          next_st.phase = srsp_pkg::SRSP_HIDLE;
        end
      end
      default: begin
        next_st.phase = srsp_pkg::SRSP_HIDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st <= '0;
      st.cs_n <= 1'b1;
      st.waitreq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign AVS_READDATA = st.readdata;
  assign AVS_WAITREQUEST = st.waitreq;
  assign LINK.sclk = st.sclk;
  assign LINK.cs_n = st.cs_n;
  assign LINK.serial_in_line = st.mosi;
endmodule : srsp_host
`default_nettype wire

//--- srsp_link_chk.sv
// Concurrent checks on the serial link joining host and device
`timescale 1ns/1ps
`default_nettype none
module srsp_link_chk (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic sdo_oe,
  // Port configuration
  input wire logic clock_idle_level,
  input wire logic clock_capture_edge,
  input wire logic serial_port_disable
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence cap_edge;
    !cs_n && $changed(sclk) && ((sclk != clock_idle_level) ^ clock_capture_edge);
  endsequence
  drive_select_a: assert property ($rose(sdo_oe) |-> !cs_n)
    else $error("output enabled while deselected");
  release_deselect_a: assert property ($rose(cs_n) |-> ##[0:5] !sdo_oe)
    else $error("output still enabled after deselect");
  quiet_deselect_a: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("output enabled while idle");
  disabled_quiet_a: assert property (serial_port_disable |-> !sdo_oe)
    else $error("output enabled while port disabled");
  idle_level_a: assert property (($fell(cs_n) || $rose(cs_n)) |-> sclk == clock_idle_level)
    else $error("serial clock not at idle level at frame edge");
  start_hold_a: assert property ($fell(cs_n) |-> $stable(sclk) [*6])
    else $error("serial clock moved too soon after select");
  half_period_a: assert property (!cs_n && $changed(sclk) |=> $stable(sclk) [*5])
    else $error("serial clock half period too short");
  sdi_capture_a: assert property (cap_edge |-> $stable(serial_in_line) ##1 $stable(serial_in_line) [*4])
    else $error("input data moved at capture edge");
  sdo_capture_a: assert property (cap_edge ##0 sdo_oe |-> $stable(serial_out_line) && $stable(sdo_oe))
    else $error("output data moved at capture edge");
  cover property ($fell(sdo_oe));
  cover property ($fell(cs_n) ##0 clock_idle_level && clock_capture_edge);
  cover property (cap_edge ##0 sdo_oe);
  cover property ($rose(serial_port_disable));
endmodule : srsp_link_chk
`default_nettype wire

//--- tb.sv
// Self-checking bench joining host and device over the serial link
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tb;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0, reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, st;
  logic avs_waitrequest;
  logic idle = 1'b0, capt = 1'b0, rev = 1'b0, dis = 1'b0, mgmt_write = 1'b0, last_sclk = 1'b0;
  logic [5:0] mgmt_addr = 6'h00;
  logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata, out_bits = 16'h0000;
  logic [23:0] wire_bits = 24'h000000;
  logic host_abort = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Design and checker
  srsp_link_if srsp_link_if_i ();
  srsp_host srsp_host_i (.CLK_SYS(clk_sys), .RESET(reset || host_abort), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .LINK(srsp_link_if_i.host));
  srsp_device srsp_device_i (.CLK_SYS(clk_sys), .RESET(reset), .LINK(srsp_link_if_i.device),
    .CLOCK_IDLE_LEVEL(idle), .CLOCK_CAPTURE_EDGE(capt), .BIT_ORDER_REVERSE(rev), .SERIAL_PORT_DISABLE(dis),
    .MGMT_ADDR(mgmt_addr), .MGMT_WRITE(mgmt_write), .MGMT_WDATA(mgmt_wdata), .MGMT_RDATA(mgmt_rdata));
  srsp_link_chk srsp_link_chk_i (.CLK_SYS(clk_sys), .RESET(reset), .sclk(srsp_link_if_i.sclk),
    .cs_n(srsp_link_if_i.cs_n), .serial_in_line(srsp_link_if_i.serial_in_line), .serial_out_line(srsp_link_if_i.serial_out_line),
    .sdo_oe(srsp_link_if_i.sdo_oe), .clock_idle_level(idle), .clock_capture_edge(capt),
    .serial_port_disable(dis));
  // ==========================================================
  // Wire monitor: bits as seen at each capture edge
  always @(posedge clk_sys) begin
    last_sclk <= srsp_link_if_i.sclk;
    if (!srsp_link_if_i.cs_n && (srsp_link_if_i.sclk != last_sclk) && ((srsp_link_if_i.sclk != idle) ^ capt)) begin
      wire_bits <= {wire_bits[22:0], srsp_link_if_i.serial_in_line};
      out_bits <= {out_bits[14:0], srsp_link_if_i.serial_out_line};
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [15:0] flip16(input logic [15:0] v);
    return {<<{v}};
  endfunction : flip16
  function automatic logic [7:0] cmd_bits(input logic r, input logic [5:0] a, input logic b);
    logic [15:0] f;
    f = flip16({a, 10'h000});
    return {r, rev ? f[5:0] : a, b};
  endfunction : cmd_bits
  task automatic conclude();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic av_xfer(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 6000);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 6000) begin
      fail_count++;
      $display("wrong value waitrequest expected 0 seen 1");
      conclude();
    end
  endtask : av_xfer
  task automatic cmd(input logic lst, input logic brs, input logic r, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    av_xfer(1'b0, srsp_pkg::OFS_CMD, {7'h00, lst, brs, r, a, d}, st);
    do begin
      av_xfer(1'b1, srsp_pkg::OFS_STATUS, 32'h0, st);
      n++;
    end while (st[srsp_pkg::STATUS_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      fail_count++;
      $display("wrong value busy expected 0 seen 1");
      conclude();
    end
  endtask : cmd
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    av_xfer(1'b1, a, 32'h0, st);
    `CHECK("read data", exp, st[15:0])
  endtask : rd_chk
  task automatic mgmt_chk(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    mgmt_addr <= a;
    repeat (2) @(posedge clk_sys);
    `CHECK("register", exp, mgmt_rdata)
  endtask : mgmt_chk
  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] dat;
    logic [5:0] adr;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(srsp_pkg::OFS_STATUS, 16'h0000);
    rd_chk(srsp_pkg::OFS_CTRL, 16'h0000);
    av_xfer(1'b0, 4'h3, 32'hffffffff, st);
    rd_chk(4'h3, 16'h0000);
    mgmt_chk(6'h3f, 16'h0000);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      adr = 6'h08 + 6'(m);
      dat = 16'hc001 + 16'(m * 16'h0130);
      @(posedge clk_sys);
      idle <= m[0];
      capt <= m[1];
      rev <= m[2];
      av_xfer(1'b0, srsp_pkg::OFS_CTRL, 32'(m), st);
      cmd(1'b1, 1'b0, 1'b0, adr, dat);
      `CHECK("write command", cmd_bits(1'b0, adr, 1'b0), wire_bits[23:16])
      `CHECK("write word", rev ? flip16(dat) : dat, wire_bits[15:0])
      mgmt_chk(adr, dat);
      cmd(1'b1, 1'b0, 1'b1, adr, 16'h0000);
      `CHECK("read command", cmd_bits(1'b1, adr, 1'b0), wire_bits[23:16])
      `CHECK("read word on wire", rev ? flip16(dat) : dat, out_bits)
      rd_chk(srsp_pkg::OFS_RDATA, dat);
    end
    $display("test modes done");
    @(posedge clk_sys);
    {idle, capt, rev} <= 3'h0;
    av_xfer(1'b0, srsp_pkg::OFS_CTRL, 32'h0, st);
    cmd(1'b0, 1'b0, 1'b0, 6'h21, 16'h5a5a);
    cmd(1'b1, 1'b0, 1'b1, 6'h21, 16'h0000);
    rd_chk(srsp_pkg::OFS_RDATA, 16'h5a5a);
    $display("test chained done");
    cmd(1'b0, 1'b1, 1'b0, 6'h1e, 16'h1111);
    `CHECK("select held", 1'b1, st[srsp_pkg::STATUS_OPEN])
    cmd(1'b0, 1'b1, 1'b0, 6'h00, 16'h2222);
    cmd(1'b1, 1'b1, 1'b0, 6'h00, 16'h3333);
    `CHECK("select released", 1'b0, st[srsp_pkg::STATUS_OPEN])
    mgmt_chk(6'h1e, 16'h1111);
    mgmt_chk(6'h1f, 16'h2222);
    mgmt_chk(6'h00, 16'h3333);
    cmd(1'b0, 1'b1, 1'b1, 6'h1f, 16'h0000);
    rd_chk(srsp_pkg::OFS_RDATA, 16'h2222);
    cmd(1'b1, 1'b1, 1'b1, 6'h00, 16'h0000);
    rd_chk(srsp_pkg::OFS_RDATA, 16'h3333);
    $display("test burst done");
    @(posedge clk_sys);
    dis <= 1'b1;
    mgmt_addr <= 6'h10;
    mgmt_wdata <= 16'h1234;
    mgmt_write <= 1'b1;
    @(posedge clk_sys);
    mgmt_write <= 1'b0;
    cmd(1'b1, 1'b0, 1'b0, 6'h10, 16'hffff);
    mgmt_chk(6'h10, 16'h1234);
    cmd(1'b1, 1'b0, 1'b1, 6'h10, 16'h0000);
    rd_chk(srsp_pkg::OFS_RDATA, 16'h0000);
    @(posedge clk_sys);
    dis <= 1'b0;
    cmd(1'b1, 1'b0, 1'b0, 6'h10, 16'h0f0f);
    mgmt_chk(6'h10, 16'h0f0f);
    $display("test disable done");
    // Host reset in mid-word: select drops after three data bits
    av_xfer(1'b0, srsp_pkg::OFS_CMD, {7'h00, 1'b1, 1'b0, 1'b0, 6'h12, 16'hbeef}, st);
    repeat (186) @(posedge clk_sys);
    host_abort <= 1'b1;
    repeat (2) @(posedge clk_sys);
    host_abort <= 1'b0;
    mgmt_chk(6'h12, 16'h0000);
    rd_chk(srsp_pkg::OFS_STATUS, 16'h0000);
    cmd(1'b1, 1'b0, 1'b0, 6'h12, 16'h5555);
    mgmt_chk(6'h12, 16'h5555);
    $display("test abort done");
    conclude();
  end
endmodule : tb
`default_nettype wire
